/* verilog/transient_list_sequencer.sv */
// Transient trigger state machine and output list sequencer with Wishbone registers.
//
// Functional notes
// [R01] Immediate trigger fires regardless of source.
// [R02] Bus source also accepts bus trigger command.
// [R03] Pin or channel source waits without timeout.
// [R04] Abort forces idle; host aborts stalled waits.
// [R05] Trigger loads each function's trigger level.
// [R06] Completed actions return system to idle.
// [R07] Status bit 6 true while action incomplete.
// [R08] Enabled step emits trigger output pulse.
// [R09] Voltage, current or both list controlled.
// [R10] Up to 512 steps, optional repetition.
// [R11] Per-step dwell 0 to 262.144 s.
// [R12] Unprogrammed dwell defaults to 0.001 s.
// [R13] Trigger pacing advances one step per trigger.
// [R14] Triggers during running dwell are discarded.
// [R15] Begin and end flag lists emit triggers.
// [R16] Mismatched list lengths raise error at run.
// [R17] Single-entry list expands to full length.
// [R18] List contents volatile, cleared by reset.
// [R19] Idle after reset ignores all triggers.
// [R20] Initiate moves idle to initiated; continuous rearms.
// [R21] Status bit 4 flags readiness; earlier triggers ignored.
// [R22] Dwell counts exact one millisecond ticks.
`timescale 1ns/1ps
`default_nettype none

module transient_list_sequencer
	import transient_list_pkg::*;
#(
	parameter int PIN_COUNT   = 7,
	parameter int CHAN_COUNT  = 4,
	parameter int LIST_DEPTH  = 512,
	parameter int LEVEL_WIDTH = 16,
	parameter int TICK_CYCLES = DWELL_TICK_CYCLES
) (
	input  wire logic                   REF_CLK_IN,
	input  wire logic                   RESET_IN,
	input  wire logic                   WB_CYC_IN,
	input  wire logic                   WB_STB_IN,
	input  wire logic                   WB_WE_IN,
	input  wire logic [7:0]             WB_ADR_IN,
	input  wire logic [3:0]             WB_SEL_IN,
	input  wire logic [31:0]            WB_DAT_IN,
	output logic      [31:0]            WB_DAT_OUT,
	output logic                        WB_ACK_OUT,
	input  wire logic [PIN_COUNT-1:0]   PIN_TRIG_IN,
	input  wire logic [CHAN_COUNT-1:0]  CHAN_TRIG_IN,
	output logic                        TRIG_OUT,
	output logic      [LEVEL_WIDTH-1:0] VOLT_LEVEL_OUT,
	output logic      [LEVEL_WIDTH-1:0] CURR_LEVEL_OUT
);

	localparam int IDX_W = $clog2(LIST_DEPTH);
	localparam int LEN_W = IDX_W + 1;
	localparam logic [LEN_W-1:0] DEPTH_LEN = LEN_W'(LIST_DEPTH);

	// ==========================================================================
	// Helpers
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] sel);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [IDX_W-1:0] entry_idx(input logic [LEN_W-1:0] len,
		input logic [IDX_W-1:0] step);
		return (len == LEN_W'(1)) ? '0 : step; // [R17]
	endfunction

	// ==========================================================================
	// Storage
	logic                   ack_q;
	logic [31:0]            rdata_q;
	logic [31:0]            rdata_d;
	logic [15:0]            mode_q;
	logic [LEVEL_WIDTH-1:0] vtrig_q;
	logic [LEVEL_WIDTH-1:0] ctrig_q;
	logic [IDX_W-1:0]       index_q;
	logic [LEN_W-1:0]       len_q [LIST_COUNT];
	logic [15:0]            repeat_q;
	logic [LEVEL_WIDTH-1:0] list_volt_q  [LIST_DEPTH];
	logic [LEVEL_WIDTH-1:0] list_curr_q  [LIST_DEPTH];
	logic [DWELL_WIDTH-1:0] list_dwell_q [LIST_DEPTH];
	logic                   begin_step_trigger_list_q [LIST_DEPTH];
	logic                   end_step_trigger_list_q   [LIST_DEPTH];

	tran_state_type         state_q;
	tran_state_type         state_d;
	logic [IDX_W-1:0]       step_q;
	logic [15:0]            rep_q;
	logic [15:0]            rep_d;
	logic [15:0]            arm_q;
	logic [15:0]            tick_q;
	logic [DWELL_WIDTH-1:0] elapsed_q;
	logic [DWELL_WIDTH-1:0] dwell_q;
	logic                   err_q;
	logic                   trig_out_q;
	logic [LEVEL_WIDTH-1:0] volt_q;
	logic [LEVEL_WIDTH-1:0] curr_q;

	// ==========================================================================
	// Bus decode
	logic       bus_req;
	logic       bus_wr;
	logic [7:0] adr;
	logic       cmd_init;
	logic       cmd_abort;
	logic       cmd_imm;
	logic       cmd_bus;
	logic       cmd_clrerr;

	assign bus_req    = WB_CYC_IN & WB_STB_IN & ~ack_q;
	assign bus_wr     = bus_req & WB_WE_IN;
	assign adr        = {WB_ADR_IN[7:2], 2'b00};
	assign WB_ACK_OUT = ack_q;
	assign WB_DAT_OUT = rdata_q;

	// Command bits are write-only strobes in the lowest byte lane.
	always_comb begin
		logic hit;
		hit        = bus_wr && (adr == OFF_COMMAND) && WB_SEL_IN[0];
		cmd_init   = hit & WB_DAT_IN[CMD_INIT_BIT];
		cmd_abort  = hit & WB_DAT_IN[CMD_ABORT_BIT];
		cmd_imm    = hit & WB_DAT_IN[CMD_IMM_BIT];
		cmd_bus    = hit & WB_DAT_IN[CMD_BUS_BIT];
		cmd_clrerr = hit & WB_DAT_IN[CMD_CLRERR_BIT];
	end

	// ==========================================================================
	// Mode decode and trigger sources
	logic                   cont_en;
	logic                   tout_en;
	logic                   vlist_en;
	logic                   clist_en;
	logic                   pace_trig;
	logic [1:0]             src_sel;
	logic [3:0]             src_idx;
	logic [PIN_COUNT-1:0]   pin_rise;
	logic [CHAN_COUNT-1:0]  chan_rise;
	logic [15:0]            pin_pad;
	logic [15:0]            chan_pad;
	logic                   trig_fire;

	assign cont_en   = mode_q[MODE_CONT_BIT];
	assign tout_en   = mode_q[MODE_TOUT_BIT];
	assign vlist_en  = mode_q[MODE_VLIST_BIT];
	assign clist_en  = mode_q[MODE_CLIST_BIT];
	assign pace_trig = mode_q[MODE_PACE_BIT];
	assign src_sel   = mode_q[MODE_SRC_LSB +: 2];
	assign src_idx   = mode_q[MODE_SEL_LSB +: 4];
	assign pin_pad   = 16'(pin_rise);
	assign chan_pad  = 16'(chan_rise);

	trigger_edge_sync #(
		.WIDTH (PIN_COUNT + CHAN_COUNT)
	) u_trigger_sync (
		.clk_in   (REF_CLK_IN),
		.reset_in (RESET_IN),
		.level_in ({CHAN_TRIG_IN, PIN_TRIG_IN}),
		.rise_out ({chan_rise, pin_rise})
	);

	// Pin and channel triggers have no timeout; only abort or an immediate trigger leaves the wait.
	assign trig_fire = cmd_imm                                  // [R01]
		| ((src_sel == SRC_BUS) & cmd_bus)                      // [R02]
		| ((src_sel == SRC_PIN) & pin_pad[src_idx])             // [R03]
		| ((src_sel == SRC_TRAN) & chan_pad[src_idx])           // [R03]
		| ((src_sel == SRC_EXT) & (|pin_rise));

	// ==========================================================================
	// List length check and entry lookup
	logic [LEN_W-1:0]       run_len;
	logic                   lens_bad;
	logic                   any_list;
	logic                   dwell_done;
	logic                   start_step;
	logic                   fire_step;
	logic                   end_pulse;
	logic                   err_set;
	logic [IDX_W-1:0]       next_idx;
	logic [DWELL_WIDTH-1:0] next_dwell;

	assign any_list = vlist_en | clist_en; // [R09]

	always_comb begin
		logic used;
		used     = 1'b0;
		run_len  = LEN_W'(1);
		lens_bad = 1'b0;
		for (int k = 0; k < LIST_COUNT; k++) begin
			used = (k == LIST_VOLT) ? vlist_en : (k == LIST_CURR) ? clist_en : 1'b1;
			if (used && len_q[k] > run_len) begin
				run_len = len_q[k];
			end
		end
		for (int k = 0; k < LIST_COUNT; k++) begin
			used = (k == LIST_VOLT) ? vlist_en : (k == LIST_CURR) ? clist_en : 1'b1;
			if (used && (len_q[k] == '0 || len_q[k] > DEPTH_LEN
				|| (len_q[k] != LEN_W'(1) && len_q[k] != run_len))) begin
				lens_bad = 1'b1; // [R16]
			end
		end
	end

	assign next_dwell = list_dwell_q[entry_idx(len_q[LIST_DWELL], next_idx)];
	assign dwell_done = (elapsed_q >= dwell_q);

	// ==========================================================================
	// Trigger state machine
	always_comb begin
		state_d    = state_q;
		rep_d      = rep_q;
		next_idx   = step_q;
		start_step = 1'b0;
		fire_step  = 1'b0;
		end_pulse  = 1'b0;
		err_set    = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (cmd_init || cont_en) begin
					state_d = ST_ARMING; // [R20]
				end
			end
			ST_ARMING: begin
				if (arm_q == 16'(ARM_CYCLES - 1)) begin
					state_d = ST_WAITING; // [R21]
				end
			end
			ST_WAITING: begin
				if (trig_fire && !any_list) begin
					fire_step = 1'b1; // [R05]
					state_d   = cont_en ? ST_ARMING : ST_IDLE; // [R06]
				end else if (trig_fire && lens_bad) begin
					err_set = 1'b1; // [R16]
					state_d = ST_IDLE;
				end else if (trig_fire) begin
					start_step = 1'b1;
					next_idx   = '0;
					rep_d      = '0;
					state_d    = ST_LIST;
				end
			end
			ST_LIST: begin
				if (dwell_done && (!pace_trig || trig_fire)) begin // [R13] [R14]
					end_pulse = 1'b1;
					if (LEN_W'(step_q) + LEN_W'(1) < run_len) begin
						start_step = 1'b1;
						next_idx   = step_q + IDX_W'(1);
					end else if (repeat_q == '0 || rep_q + 16'h0001 < repeat_q) begin
						start_step = 1'b1; // [R10]
						next_idx   = '0;
						rep_d      = rep_q + 16'h0001;
					end else begin
						state_d = cont_en ? ST_ARMING : ST_IDLE; // [R06]
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (cmd_abort) begin
			state_d    = ST_IDLE; // [R04]
			start_step = 1'b0;
			fire_step  = 1'b0;
			end_pulse  = 1'b0;
			err_set    = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			state_q <= ST_IDLE; // [R19]
			step_q  <= '0;
			rep_q   <= '0;
		end else begin
			state_q <= state_d;
			rep_q   <= rep_d;
			if (start_step) begin
				step_q <= next_idx;
			end
		end
	end

	// ==========================================================================
	// Timers
	// A whole millisecond tick keeps every programmable dwell exact, at the cost
	// of a counter that must be shortened by parameter in simulation.
	always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			arm_q     <= '0;
			tick_q    <= '0;
			elapsed_q <= '0;
			dwell_q   <= '0;
		end else begin
			arm_q <= (state_q == ST_ARMING) ? arm_q + 16'h0001 : 16'h0000;
			if (start_step) begin
				tick_q    <= '0;
				elapsed_q <= '0;
				dwell_q   <= next_dwell; // [R11]
			end else if (state_q == ST_LIST && !dwell_done) begin
				if (tick_q == 16'(TICK_CYCLES - 1)) begin
					tick_q    <= '0;
					elapsed_q <= elapsed_q + DWELL_WIDTH'(1); // [R22]
				end else begin
					tick_q <= tick_q + 16'h0001;
				end
			end
		end
	end

	// ==========================================================================
	// Outputs: levels and trigger pulse
	logic                   begin_hit;
	logic                   end_hit;

	assign begin_hit = begin_step_trigger_list_q[entry_idx(len_q[LIST_BEGIN_STEP], next_idx)];
	assign end_hit   = end_step_trigger_list_q[entry_idx(len_q[LIST_END_STEP], step_q)];

	always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			volt_q     <= '0;
			curr_q     <= '0;
			trig_out_q <= 1'b0;
		end else begin
			if (fire_step) begin
				volt_q <= vtrig_q; // [R05]
				curr_q <= ctrig_q;
			end else if (start_step) begin
				volt_q <= vlist_en ? list_volt_q[entry_idx(len_q[LIST_VOLT], next_idx)]
					: vtrig_q; // [R09]
				curr_q <= clist_en ? list_curr_q[entry_idx(len_q[LIST_CURR], next_idx)]
					: ctrig_q;
			end
			trig_out_q <= (fire_step & tout_en) // [R08]
				| (start_step & begin_hit) // [R15]
				| (end_pulse & end_hit); // [R15]
		end
	end

	assign TRIG_OUT       = trig_out_q;
	assign VOLT_LEVEL_OUT = volt_q;
	assign CURR_LEVEL_OUT = curr_q;

	// Error stays until cleared; a new error in the clearing cycle wins.
	always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			err_q <= 1'b0;
		end else if (err_set) begin
			err_q <= 1'b1; // [R16]
		end else if (cmd_clrerr) begin
			err_q <= 1'b0;
		end
	end

	// ==========================================================================
	// Configuration registers
	always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			mode_q   <= '0;
			vtrig_q  <= '0;
			ctrig_q  <= '0;
			index_q  <= '0;
			repeat_q <= REPEAT_RESET;
			for (int k = 0; k < LIST_COUNT; k++) begin
				len_q[k] <= LEN_W'(1);
			end
		end else if (bus_wr) begin
			if (adr == OFF_MODE) begin
				mode_q <= 16'(merge_bytes({16'h0000, mode_q}, WB_DAT_IN, WB_SEL_IN));
			end else if (adr == OFF_VOLT_TRIG) begin
				vtrig_q <= LEVEL_WIDTH'(merge_bytes(32'(vtrig_q), WB_DAT_IN, WB_SEL_IN));
			end else if (adr == OFF_CURR_TRIG) begin
				ctrig_q <= LEVEL_WIDTH'(merge_bytes(32'(ctrig_q), WB_DAT_IN, WB_SEL_IN));
			end else if (adr == OFF_LIST_INDEX) begin
				index_q <= IDX_W'(merge_bytes(32'(index_q), WB_DAT_IN, WB_SEL_IN));
			end else if (adr == OFF_REPEAT) begin
				repeat_q <= 16'(merge_bytes({16'h0000, repeat_q}, WB_DAT_IN, WB_SEL_IN));
			end else begin
				for (int k = 0; k < LIST_COUNT; k++) begin
					if (adr == OFF_LEN_BASE + 8'(4 * k)) begin
						len_q[k] <= LEN_W'(merge_bytes(32'(len_q[k]), WB_DAT_IN, WB_SEL_IN));
					end
				end
			end
		end
	end

	// ==========================================================================
	// List storage: flip-flops only, so every entry is lost at power loss.
	always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			for (int i = 0; i < LIST_DEPTH; i++) begin
				list_volt_q[i]  <= '0; // [R18]
				list_curr_q[i]  <= '0;
				list_dwell_q[i] <= DWELL_RESET_MS; // [R12]
				begin_step_trigger_list_q[i] <= 1'b0;
				end_step_trigger_list_q[i]   <= 1'b0;
			end
		end else if (bus_wr) begin
			if (adr == OFF_LIST_VOLT) begin
				list_volt_q[index_q] <= LEVEL_WIDTH'(merge_bytes(32'(list_volt_q[index_q]),
					WB_DAT_IN, WB_SEL_IN));
			end else if (adr == OFF_LIST_CURR) begin
				list_curr_q[index_q] <= LEVEL_WIDTH'(merge_bytes(32'(list_curr_q[index_q]),
					WB_DAT_IN, WB_SEL_IN));
			end else if (adr == OFF_LIST_DWELL) begin
				// Values past the longest dwell saturate rather than wrap.
				if (WB_DAT_IN > 32'(DWELL_MAX_MS)) begin
					list_dwell_q[index_q] <= DWELL_MAX_MS; // [R11]
				end else begin
					list_dwell_q[index_q] <= DWELL_WIDTH'(WB_DAT_IN);
				end
			end else if (adr == OFF_LIST_FLAGS && WB_SEL_IN[0]) begin
				begin_step_trigger_list_q[index_q] <= WB_DAT_IN[FLAG_BEGIN_BIT];
				end_step_trigger_list_q[index_q]   <= WB_DAT_IN[FLAG_END_BIT];
			end
		end
	end

	// ==========================================================================
	// Read mux and acknowledge
	always_comb begin
		rdata_d = 32'h00000000;
		if (adr == OFF_MODE) begin
			rdata_d = {16'h0000, mode_q};
		end else if (adr == OFF_STATUS) begin
			rdata_d[STAT_WAIT_BIT] = (state_q == ST_WAITING)
				|| (state_q == ST_LIST && pace_trig && dwell_done); // [R21]
			rdata_d[STAT_ACTIVE_BIT] = (state_q != ST_IDLE); // [R07]
			rdata_d[STAT_ERR_BIT] = err_q;
			rdata_d[STAT_STEP_LSB +: IDX_W] = step_q;
		end else if (adr == OFF_VOLT_TRIG) begin
			rdata_d = 32'(vtrig_q);
		end else if (adr == OFF_CURR_TRIG) begin
			rdata_d = 32'(ctrig_q);
		end else if (adr == OFF_LIST_INDEX) begin
			rdata_d = 32'(index_q);
		end else if (adr == OFF_LIST_VOLT) begin
			rdata_d = 32'(list_volt_q[index_q]);
		end else if (adr == OFF_LIST_CURR) begin
			rdata_d = 32'(list_curr_q[index_q]);
		end else if (adr == OFF_LIST_DWELL) begin
			rdata_d = 32'(list_dwell_q[index_q]);
		end else if (adr == OFF_LIST_FLAGS) begin
			rdata_d = {30'h00000000, end_step_trigger_list_q[index_q],
				begin_step_trigger_list_q[index_q]};
		end else if (adr == OFF_REPEAT) begin
			rdata_d = {16'h0000, repeat_q};
		end else if (adr == OFF_LEVEL_OUT) begin
			rdata_d = {curr_q, volt_q};
		end else begin
			for (int k = 0; k < LIST_COUNT; k++) begin
				if (adr == OFF_LEN_BASE + 8'(4 * k)) begin
					rdata_d = 32'(len_q[k]);
				end
			end
		end
	end

	always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			ack_q   <= 1'b0;
			rdata_q <= '0;
		end else begin
			ack_q <= bus_req;
			if (bus_req && !WB_WE_IN) begin
				rdata_q <= rdata_d;
			end
		end
	end

endmodule

`default_nettype wire

/* verilog/transient_list_pkg.sv */
// Constants, register map and types shared by the transient list sequencer.
package transient_list_pkg;

	// ==========================================================================
	// Clock and timing
	localparam int CLK_PERIOD_NS     = 100;
	localparam int DWELL_TICK_NS     = 1000000;
	localparam int DWELL_TICK_CYCLES = DWELL_TICK_NS / CLK_PERIOD_NS;
	localparam int ARM_TIME_NS       = 1000;
	localparam int ARM_CYCLES        = (ARM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================================
	// List geometry and reset values
	localparam int              DWELL_WIDTH     = 19;
	localparam logic [18:0]     DWELL_MAX_MS    = 19'h40000;
	localparam logic [18:0]     DWELL_RESET_MS  = 19'h00001;
	localparam logic [15:0]     REPEAT_RESET    = 16'h0001;
	localparam int              LIST_COUNT      = 5;
	localparam int              LIST_VOLT       = 0;
	localparam int              LIST_CURR       = 1;
	localparam int              LIST_DWELL      = 2;
	localparam int              LIST_BEGIN_STEP = 3;
	localparam int              LIST_END_STEP   = 4;

	// ==========================================================================
	// Register byte offsets
	localparam logic [7:0] OFF_COMMAND    = 8'h00;
	localparam logic [7:0] OFF_MODE       = 8'h04;
	localparam logic [7:0] OFF_STATUS     = 8'h08;
	localparam logic [7:0] OFF_VOLT_TRIG  = 8'h0C;
	localparam logic [7:0] OFF_CURR_TRIG  = 8'h10;
	localparam logic [7:0] OFF_LIST_INDEX = 8'h14;
	localparam logic [7:0] OFF_LIST_VOLT  = 8'h18;
	localparam logic [7:0] OFF_LIST_CURR  = 8'h1C;
	localparam logic [7:0] OFF_LIST_DWELL = 8'h20;
	localparam logic [7:0] OFF_LIST_FLAGS = 8'h24;
	localparam logic [7:0] OFF_LEN_BASE   = 8'h28;
	localparam logic [7:0] OFF_REPEAT     = 8'h3C;
	localparam logic [7:0] OFF_LEVEL_OUT  = 8'h40;

	// ==========================================================================
	// Field positions
	localparam int CMD_INIT_BIT    = 0;
	localparam int CMD_ABORT_BIT   = 1;
	localparam int CMD_IMM_BIT     = 2;
	localparam int CMD_BUS_BIT     = 3;
	localparam int CMD_CLRERR_BIT  = 4;
	localparam int MODE_CONT_BIT   = 0;
	localparam int MODE_TOUT_BIT   = 1;
	localparam int MODE_VLIST_BIT  = 2;
	localparam int MODE_CLIST_BIT  = 3;
	localparam int MODE_PACE_BIT   = 4;
	localparam int MODE_SRC_LSB    = 8;
	localparam int MODE_SEL_LSB    = 12;
	localparam int STAT_WAIT_BIT   = 4;
	localparam int STAT_ACTIVE_BIT = 6;
	localparam int STAT_ERR_BIT    = 8;
	localparam int STAT_STEP_LSB   = 16;
	localparam int FLAG_BEGIN_BIT  = 0;
	localparam int FLAG_END_BIT    = 1;

	// ==========================================================================
	// Trigger source codes
	localparam logic [1:0] SRC_BUS  = 2'h0;
	localparam logic [1:0] SRC_PIN  = 2'h1;
	localparam logic [1:0] SRC_TRAN = 2'h2;
	localparam logic [1:0] SRC_EXT  = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMING,
		ST_WAITING,
		ST_LIST
	} tran_state_type;

endpackage

/* verilog/trigger_edge_sync.sv */
// Three-stage synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/1ps
`default_nettype none

module trigger_edge_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic [WIDTH-1:0] level_in,
	output logic      [WIDTH-1:0] rise_out
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] stable_q;
	logic [WIDTH-1:0] stable_d;
	logic [WIDTH-1:0] rise_q;

	// A bit only changes once the second and third stages agree.
	assign stable_d = (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
	assign rise_out = rise_q;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			s1_q     <= '0;
			s2_q     <= '0;
			s3_q     <= '0;
			stable_q <= '0;
			rise_q   <= '0;
		end else begin
			s1_q     <= level_in;
			s2_q     <= s1_q;
			s3_q     <= s2_q;
			stable_q <= stable_d;
			rise_q   <= stable_d & ~stable_q;
		end
	end

endmodule

`default_nettype wire

/* verif/trig_source_model.sv */
// Model of the trigger pins and of the other channels' trigger lines.
`timescale 1ns/1ps
`default_nettype none
module trig_source_model (
	input  wire logic       clk_in,
	output logic      [6:0] pins_out,
	output logic      [3:0] chans_out
);
	initial begin
		pins_out = 7'h00;
		chans_out = 4'h0;
	end
	// Held six clocks; the synchroniser filter only drops glitches of a single clock.
	task automatic pulse(input logic [7:0] c);
		@(posedge clk_in);
		if (c[5]) chans_out[c[1:0]] <= 1'b1;
		else pins_out[c[2:0]] <= 1'b1;
		repeat (6) @(posedge clk_in);
		pins_out <= 7'h00;
		chans_out <= 4'h0;
	endtask
endmodule
`default_nettype wire

/* verif/transient_list_sequencer_props.sv */
// Bus handshake and output properties of the transient list sequencer.
`timescale 1ns/1ps
`default_nettype none
module transient_list_sequencer_props #(
	parameter int LEVEL_WIDTH = 16
) (
	input wire logic                   REF_CLK_IN,
	input wire logic                   RESET_IN,
	input wire logic                   WB_CYC_IN,
	input wire logic                   WB_STB_IN,
	input wire logic                   WB_WE_IN,
	input wire logic [7:0]             WB_ADR_IN,
	input wire logic [3:0]             WB_SEL_IN,
	input wire logic [31:0]            WB_DAT_IN,
	input wire logic [31:0]            WB_DAT_OUT,
	input wire logic                   WB_ACK_OUT,
	input wire logic                   TRIG_OUT,
	input wire logic [LEVEL_WIDTH-1:0] VOLT_LEVEL_OUT,
	input wire logic [LEVEL_WIDTH-1:0] CURR_LEVEL_OUT
);
	default clocking @(posedge REF_CLK_IN);
	endclocking
	default disable iff (RESET_IN);
	wire logic take = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
	wire logic rd = take && !WB_WE_IN;
	// ====
	// Register bus
	ack_after_req_a: assert property (take |=> WB_ACK_OUT) else $error("ack missing");
	ack_single_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack too long");
	read_hold_a: assert property (!rd |=> $stable(WB_DAT_OUT)) else $error("read data moved");
	unmapped_zero_a: assert property (rd && WB_ADR_IN[7:2] > 6'h10 |=> WB_DAT_OUT == 32'h0)
		else $error("unmapped read not zero");
	// ====
	// Trigger system
	level_readback_a: assert property (rd && WB_ADR_IN[7:2] == 6'h10 |=>
		WB_DAT_OUT == {$past(CURR_LEVEL_OUT), $past(VOLT_LEVEL_OUT)}) else $error("level read");
	wait_active_a: assert property (rd && WB_ADR_IN[7:2] == 6'h02 |=>
		!WB_DAT_OUT[4] || WB_DAT_OUT[6]) else $error("waiting while idle");
	reset_idle_a: assert property ($fell(RESET_IN) |->
		VOLT_LEVEL_OUT == 0 && CURR_LEVEL_OUT == 0 && !TRIG_OUT) else $error("reset levels");
	abort_quiet_a: assert property (take && WB_WE_IN && WB_ADR_IN[7:2] == 6'h00 &&
		WB_SEL_IN[0] && WB_DAT_IN[1] |-> ##2 $stable(VOLT_LEVEL_OUT)[*6]) else $error("abort");
	cover property (TRIG_OUT);
	cover property ($changed(VOLT_LEVEL_OUT));
	cover property (WB_ACK_OUT && WB_DAT_OUT[4]);
endmodule
bind transient_list_sequencer transient_list_sequencer_props #(.LEVEL_WIDTH(LEVEL_WIDTH)) u_props (
	.REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN), .WB_CYC_IN(WB_CYC_IN),
	.WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN),
	.WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
	.TRIG_OUT(TRIG_OUT), .VOLT_LEVEL_OUT(VOLT_LEVEL_OUT), .CURR_LEVEL_OUT(CURR_LEVEL_OUT));
`default_nettype wire

/* verif/tb.sv */
// Directed bench driving the sequencer through its register bus and pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import transient_list_pkg::*;
	localparam int TK = 4;
	logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, trg;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0, q, rdat;
	logic [6:0]  pins;
	logic [3:0]  chans;
	logic [15:0] vo;
	int          num_errors = 0, checked = 0, pulses = 0, n;
	logic [15:0] md [5] = '{16'h0002, 16'h2102, 16'h1202, 16'h0302, 16'h2102};
	logic [7:0]  tk [5] = '{8'h08, 8'h12, 8'h21, 8'h15, 8'h04};
	always #50 clk = ~clk;
	always @(posedge clk) begin
		if (trg === 1'b1) pulses <= pulses + 1;
	end
	transient_list_sequencer #(.TICK_CYCLES(TK)) DUT (.REF_CLK_IN(clk), .RESET_IN(rst),
		.WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF),
		.WB_DAT_IN(dat), .WB_DAT_OUT(q), .WB_ACK_OUT(ack), .PIN_TRIG_IN(pins),
		.CHAN_TRIG_IN(chans), .TRIG_OUT(trg), .VOLT_LEVEL_OUT(vo), .CURR_LEVEL_OUT());
	trig_source_model src (.clk_in(clk), .pins_out(pins), .chans_out(chans));
	// ====
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rdat = q;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic ready();
		do begin
			wb(1'b0, OFF_STATUS, 32'h0);
		end while (rdat[STAT_WAIT_BIT] !== 1'b1);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ====
	// Watchdog, far beyond the few hundred cycles the tests need.
	initial begin
		#2000000;
		num_errors++;
		conclude();
	end
	// ====
	// Tests
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wb(1'b1, OFF_CURR_TRIG, 32'h0567);
		wb(1'b0, OFF_LIST_DWELL, 32'h0);
		chk(rdat, 32'h1);
		wb(1'b1, OFF_COMMAND, 32'h4);
		wb(1'b0, OFF_LEVEL_OUT, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b0, 8'hFC, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b1, OFF_MODE, 32'h2102);
		wb(1'b1, OFF_COMMAND, 32'h1);
		wb(1'b1, OFF_COMMAND, 32'h4);
		wb(1'b0, OFF_LEVEL_OUT, 32'h0);
		chk(rdat, 32'h0);
		ready();
		repeat (50) @(posedge clk);
		wb(1'b0, OFF_STATUS, 32'h0);
		chk(rdat[8:0], 32'h50);
		wb(1'b1, OFF_COMMAND, 32'h2);
		wb(1'b0, OFF_STATUS, 32'h0);
		chk(rdat[8:0], 32'h0);
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, OFF_VOLT_TRIG, 32'h100 + i);
			wb(1'b1, OFF_MODE, {16'h0, md[i]});
			wb(1'b1, OFF_COMMAND, 32'h1);
			ready();
			if (tk[i] > 8'h10) src.pulse(tk[i]);
			else wb(1'b1, OFF_COMMAND, {24'h0, tk[i]});
			repeat (6) @(posedge clk);
			wb(1'b0, OFF_LEVEL_OUT, 32'h0);
			chk(rdat, 32'h05670100 + i);
			chk(pulses, i + 1);
			wb(1'b0, OFF_STATUS, 32'h0);
			chk(rdat[8:0], 32'h0);
		end
		wb(1'b1, OFF_MODE, 32'h4);
		wb(1'b1, OFF_LIST_VOLT, 32'h11);
		wb(1'b1, OFF_LIST_DWELL, 32'h2);
		wb(1'b1, OFF_LIST_FLAGS, 32'h1);
		wb(1'b1, OFF_LIST_INDEX, 32'h1);
		wb(1'b1, OFF_LIST_VOLT, 32'h22);
		wb(1'b1, OFF_LEN_BASE, 32'h2);
		wb(1'b1, OFF_COMMAND, 32'h1);
		ready();
		wb(1'b1, OFF_COMMAND, 32'h4);
		chk(vo, 32'h11);
		n = 0;
		while (vo !== 16'h22 && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk(n > TK && n <= 2 * TK, 32'h1);
		repeat (3 * TK) @(posedge clk);
		chk(pulses, 32'h7);
		wb(1'b0, OFF_STATUS, 32'h0);
		chk(rdat[8:0], 32'h0);
		wb(1'b1, OFF_LEN_BASE + 8'h08, 32'h3);
		wb(1'b1, OFF_COMMAND, 32'h1);
		repeat (12) @(posedge clk);
		wb(1'b1, OFF_COMMAND, 32'h4);
		wb(1'b0, OFF_STATUS, 32'h0);
		chk(rdat[8], 32'h1);
		wb(1'b1, OFF_COMMAND, 32'h10);
		wb(1'b0, OFF_STATUS, 32'h0);
		chk(rdat[8:0], 32'h0);
		wb(1'b1, OFF_LEN_BASE + 8'h08, 32'h1);
		wb(1'b1, OFF_MODE, 32'h14);
		wb(1'b1, OFF_COMMAND, 32'h1);
		ready();
		wb(1'b1, OFF_COMMAND, 32'h4);
		wb(1'b1, OFF_COMMAND, 32'h4);
		chk(vo, 32'h11);
		ready();
		wb(1'b1, OFF_COMMAND, 32'h8);
		chk(vo, 32'h22);
		ready();
		wb(1'b1, OFF_COMMAND, 32'h4);
		wb(1'b0, OFF_STATUS, 32'h0);
		chk(rdat[8:0], 32'h0);
		chk(pulses, 32'h9);
		conclude();
	end
endmodule
`default_nettype wire
